// ===== rtl/cpms_top.sv
// top: chip power mode sequencer with run, wait, stop and low-power variants
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
// Functional notes
// - reset lands in normal run, regulator full
// - only the sleep instruction enters wait/stop
// - normal wait: core sleeps, peripherals clocked, interrupt wakes
// - normal stop: clocks gated, state kept, lvd on
// - stop: controller off, async detector wakes chip
// - vlp run: low regulator, slow flash, lvd off
// - pin states held in every wait and stop mode
// - each run mode has wait and stop
// - vlp wait: like vlp run, core sleeps
// - vlp stop: static, lvd off, async wake
module cpms_top
    import cpms_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   wait_for_irq_instruction, // one-cycle pulse from core
    input  wire logic                   deep_sleep,      // core deep-sleep indication
    input  wire logic                   irq_pending,     // nested_irq_controller request
    input  wire logic                   async_wake,      // raw async_wakeup_controller line
    input  wire logic [CPMS_ADDR_W-1:0] addr,
    input  wire logic [CPMS_DATA_W-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [CPMS_DATA_W-1:0] rdata,
    output logic      [2:0]             mode,            // current mode code
    output logic                        core_clk_en,     // core clock running
    output logic                        periph_clk_en,   // peripheral clocks running
    output logic                        regulator_lp,    // regulator in low-power state
    output logic                        flash_slow,      // reduced-frequency flash access
    output logic                        low_voltage_detect_en,
    output logic                        nested_irq_controller_en,
    output logic                        async_wakeup_controller_en,
    output logic                        io_hold          // pin states frozen
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    cpms_mode_e             state_r;     // current power mode
    cpms_mode_e             state_nxt;   // next power mode
    logic [CPMS_DATA_W-1:0] ctrl_r;      // software control register
    logic [CPMS_DATA_W-1:0] rdata_r;     // registered read answer
    logic [2:0]             mode_r;
    logic                   core_clk_r;
    logic                   periph_clk_r;
    logic                   reg_lp_r;
    logic                   flash_slow_r;
    logic                   lvd_r;
    logic                   nested_irq_controller_r;
    logic                   async_wakeup_controller_r;
    logic                   io_hold_r;
    cpms_wake_if            wk ();       // link to the wake detector

    // returns the status code of a mode
    function automatic logic [2:0] mode_code(input cpms_mode_e m);
        unique case (m)
            CPMS_RUN:      mode_code = CPMS_MODE_RUN;
            CPMS_WAIT:     mode_code = CPMS_MODE_WAIT;
            CPMS_STOP:     mode_code = CPMS_MODE_STOP;
            CPMS_VLP_RUN:  mode_code = CPMS_MODE_VRUN;
            CPMS_VLP_WAIT: mode_code = CPMS_MODE_VWAIT;
            default:       mode_code = CPMS_MODE_VSTOP;
        endcase
    endfunction

    // true for the three very-low-power modes
    function automatic logic is_vlp(input cpms_mode_e m);
        is_vlp = (m == CPMS_VLP_RUN) || (m == CPMS_VLP_WAIT) || (m == CPMS_VLP_STOP);
    endfunction

    // true for the two stop modes
    function automatic logic is_stop(input cpms_mode_e m);
        is_stop = (m == CPMS_STOP) || (m == CPMS_VLP_STOP);
    endfunction

    // true for the two wait modes
    function automatic logic is_wait(input cpms_mode_e m);
        is_wait = (m == CPMS_WAIT) || (m == CPMS_VLP_WAIT);
    endfunction

    // ------------------------------------------------------------
    // wake detector
    // ------------------------------------------------------------
    cpms_wake u_wake (
        .clk        (clk),
        .rst_b      (rst_b),
        .async_wake (async_wake),
        .wk         (wk.wake)
    );

    // arm the detector only in stop, so waits use the interrupt controller
    assign wk.arm = async_wakeup_controller_r;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // control register; vlp request only takes effect from a run mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CPMS_CTRL_RST;
        end else if (wr && addr == CPMS_CTRL_OFS) begin
            ctrl_r <= wdata;
        end
    end

    // read data appear in the cycle after the strobe and only there
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= CPMS_RD_ZERO;
        end else if (rd && addr == CPMS_CTRL_OFS) begin
            rdata_r <= ctrl_r;
        end else if (rd && addr == CPMS_STAT_OFS) begin
            // status shows the live mode code
            rdata_r <= {5'h00, mode_code(state_r)};
        end else begin
            rdata_r <= CPMS_RD_ZERO;  // unmapped or idle reads zero
        end
    end

    // ------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------
    // next mode; a run mode falls into its own wait or stop
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CPMS_RUN: begin
                if (wait_for_irq_instruction) begin
                    state_nxt = deep_sleep ? CPMS_STOP : CPMS_WAIT;
                end else if (ctrl_r[CPMS_CTRL_VLP_B]) begin
                    state_nxt = CPMS_VLP_RUN;
                end
            end
            CPMS_VLP_RUN: begin
                if (wait_for_irq_instruction) begin
                    state_nxt = deep_sleep ? CPMS_VLP_STOP : CPMS_VLP_WAIT;
                end else if (!ctrl_r[CPMS_CTRL_VLP_B]) begin
                    state_nxt = CPMS_RUN;
                end
            end
            // any interrupt ends a wait
            CPMS_WAIT: begin
                if (irq_pending) begin
                    state_nxt = CPMS_RUN;
                end
            end
            CPMS_VLP_WAIT: begin
                if (irq_pending) begin
                    state_nxt = CPMS_VLP_RUN;
                end
            end
            // stops return only through the async detector
            CPMS_STOP: begin
                if (wk.stop_wake) begin
                    state_nxt = CPMS_RUN;
                end
            end
            CPMS_VLP_STOP: begin
                if (wk.stop_wake) begin
                    state_nxt = CPMS_VLP_RUN;
                end
            end
            default: state_nxt = CPMS_RUN;  // illegal code recovers to run
        endcase
    end

    // mode register; reset always lands in full-power run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= CPMS_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // mode outputs, registered from the next mode so they track state_r
    // ------------------------------------------------------------
    // the clock source choice in vlp run is software's; this block
    // only drops the regulator and flash rate and turns lvd off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r       <= CPMS_MODE_RUN;
            core_clk_r   <= 1'b1;
            periph_clk_r <= 1'b1;
            reg_lp_r     <= 1'b0;  // regulator full on
            flash_slow_r <= 1'b0;
            lvd_r        <= 1'b1;
            nested_irq_controller_r       <= 1'b1;
            async_wakeup_controller_r       <= 1'b0;
            io_hold_r    <= 1'b0;
        end else begin
            mode_r       <= mode_code(state_nxt);
            core_clk_r   <= !is_wait(state_nxt) && !is_stop(state_nxt);
            periph_clk_r <= !is_stop(state_nxt);
            reg_lp_r     <= is_vlp(state_nxt);
            flash_slow_r <= is_vlp(state_nxt);
            // lvd stays on in normal stop, off in all vlp modes
            lvd_r        <= !is_vlp(state_nxt);
            nested_irq_controller_r       <= !is_stop(state_nxt);
            async_wakeup_controller_r       <= is_stop(state_nxt);
            // pins frozen in every wait and stop mode so their levels survive
            io_hold_r    <= is_wait(state_nxt) || is_stop(state_nxt);
        end
    end

    assign rdata                      = rdata_r;
    assign mode                       = mode_r;
    assign core_clk_en                = core_clk_r;
    assign periph_clk_en              = periph_clk_r;
    assign regulator_lp               = reg_lp_r;
    assign flash_slow                 = flash_slow_r;
    assign low_voltage_detect_en      = lvd_r;
    assign nested_irq_controller_en   = nested_irq_controller_r;
    assign async_wakeup_controller_en = async_wakeup_controller_r;
    assign io_hold                    = io_hold_r;
endmodule

// ===== rtl/cpms_pkg.sv
// package: modes, register map and field layout of the power mode sequencer
package cpms_pkg;
    // chip power modes
    typedef enum logic [2:0] {
        CPMS_RUN,
        CPMS_WAIT,
        CPMS_STOP,
        CPMS_VLP_RUN,
        CPMS_VLP_WAIT,
        CPMS_VLP_STOP
    } cpms_mode_e;

    localparam int          CPMS_ADDR_W     = 4;
    localparam int          CPMS_DATA_W     = 8;
    localparam logic [3:0]  CPMS_CTRL_OFS   = 4'h0;  // control register
    localparam logic [3:0]  CPMS_STAT_OFS   = 4'h4;  // status register
    localparam int          CPMS_CTRL_VLP_B = 0;     // ctrl: request very-low-power run
    localparam logic [7:0]  CPMS_CTRL_RST   = 8'h00; // ctrl reset value
    localparam logic [7:0]  CPMS_RD_ZERO    = 8'h00; // unmapped / reserved read value
    localparam logic [2:0]  CPMS_MODE_RUN   = 3'h0;  // status code of normal run
    localparam logic [2:0]  CPMS_MODE_WAIT  = 3'h1;
    localparam logic [2:0]  CPMS_MODE_STOP  = 3'h2;
    localparam logic [2:0]  CPMS_MODE_VRUN  = 3'h3;
    localparam logic [2:0]  CPMS_MODE_VWAIT = 3'h4;
    localparam logic [2:0]  CPMS_MODE_VSTOP = 3'h5;
    localparam int          CPMS_STAT_MODE_LSB = 0;  // stat[2:0]: current mode code
    localparam int          CPMS_FLASH_SLOW_KHZ = 1000; // reduced flash access rate
endpackage

// ===== rtl/cpms_wake_if.sv
// interface: wake handshake between sequencer and async wake-up detector
`timescale 1ns/1ps
interface cpms_wake_if;
    logic arm;        // wake-up controller primed (stop modes)
    logic stop_wake;  // synchronised wake request while armed

    modport seq  (output arm, input  stop_wake);
    modport wake (input  arm, output stop_wake);
endinterface

// ===== rtl/cpms_wake.sv
// async wake-up detector: synchronises the raw wake line, gated by arm
`timescale 1ns/1ps
module cpms_wake
    import cpms_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_b,
    input  wire logic   async_wake,  // raw wake line, no clock relation
    cpms_wake_if.wake   wk
);
    logic sync1_r;  // first stage, read only by sync2_r
    logic sync2_r;  // second stage, safe to use
    logic wake_r;   // armed wake request

    // ------------------------------------------------------------
    // two-flop synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= async_wake;
            sync2_r <= sync1_r;
        end
    end

    // only an armed detector reports; the interrupt controller is off then
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wk.arm & sync2_r;
        end
    end

    assign wk.stop_wake = wake_r;
endmodule

// ===== tb/cpms_top_sva.sv
// checker: timing relations between the sequencer's request inputs and mode outputs
`timescale 1ns/1ps
module cpms_top_sva
    import cpms_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   wait_for_irq_instruction,
    input wire logic                   deep_sleep,
    input wire logic                   irq_pending,
    input wire logic                   async_wake,
    input wire logic [CPMS_ADDR_W-1:0] addr,
    input wire logic [CPMS_DATA_W-1:0] wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [CPMS_DATA_W-1:0] rdata,
    input wire logic [2:0]             mode,
    input wire logic                   core_clk_en,
    input wire logic                   periph_clk_en,
    input wire logic                   regulator_lp,
    input wire logic                   flash_slow,
    input wire logic                   low_voltage_detect_en,
    input wire logic                   nested_irq_controller_en,
    input wire logic                   async_wakeup_controller_en,
    input wire logic                   io_hold
);
    // ----------------------------------------
    // assertions, all in the one clock domain
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // sleep strobe taken while in full-power run
    sequence s_run_sleep;
        mode == CPMS_MODE_RUN && wait_for_irq_instruction;
    endsequence
    // run, then a sleep mode on the next edge
    sequence s_fell_asleep;
        (mode == CPMS_MODE_RUN) ##1 (mode == CPMS_MODE_WAIT || mode == CPMS_MODE_STOP);
    endsequence
    reset_run_a: assert property ($rose(rst_b) |-> mode == CPMS_MODE_RUN && !regulator_lp)
        else $error("mode not run after reset");
    wait_entry_a: assert property (s_run_sleep ##0 !deep_sleep |-> ##[1:2] mode == CPMS_MODE_WAIT)
        else $error("strobe did not enter wait");
    stop_entry_a: assert property (s_run_sleep ##0 deep_sleep |-> ##[1:2] mode == CPMS_MODE_STOP)
        else $error("strobe did not enter stop");
    sleep_cause_a: assert property (s_fell_asleep |-> $past(wait_for_irq_instruction, 2) || $past(wait_for_irq_instruction))
        else $error("sleep entered without strobe");
    wait_state_a: assert property (mode == CPMS_MODE_WAIT |-> !core_clk_en && periph_clk_en && nested_irq_controller_en && io_hold)
        else $error("wait mode enables wrong");
    stop_state_a: assert property (mode == CPMS_MODE_STOP |-> !periph_clk_en && low_voltage_detect_en && !nested_irq_controller_en && async_wakeup_controller_en)
        else $error("stop mode enables wrong");
    vlp_run_a: assert property (mode == CPMS_MODE_VRUN |-> regulator_lp && flash_slow && !low_voltage_detect_en && core_clk_en)
        else $error("vlp run enables wrong");
    vlp_sleep_a: assert property (mode == CPMS_MODE_VWAIT || mode == CPMS_MODE_VSTOP |-> regulator_lp && !low_voltage_detect_en && io_hold)
        else $error("vlp sleep enables wrong");
    irq_exit_a: assert property (mode == CPMS_MODE_WAIT && irq_pending |-> ##[1:2] mode == CPMS_MODE_RUN)
        else $error("interrupt did not end wait");
    wake_exit_a: assert property (mode == CPMS_MODE_STOP && async_wake |-> ##[1:6] mode == CPMS_MODE_RUN)
        else $error("wake did not end stop");
    read_idle_a: assert property (!$past(rd) |-> rdata == CPMS_RD_ZERO)
        else $error("read data outside read answer");
endmodule
bind cpms_top cpms_top_sva i_cpms_top_sva (.clk, .rst_b, .wait_for_irq_instruction, .deep_sleep,
    .irq_pending, .async_wake, .addr, .wdata, .wr, .rd, .rdata, .mode, .core_clk_en,
    .periph_clk_en, .regulator_lp, .flash_slow, .low_voltage_detect_en,
    .nested_irq_controller_en, .async_wakeup_controller_en, .io_hold);

// ===== tb/cpms_core_model.sv
// partner: core and interrupt source that ask the sequencer to sleep and wake
`timescale 1ns/1ps
module cpms_core_model
    import cpms_pkg::*;
(
    input  wire logic clk,
    output logic      wait_for_irq_instruction,
    output logic      deep_sleep,
    output logic      irq_pending,
    output logic      async_wake
);
    // quiet core at time zero; clock source choice stays with software
    initial begin
        wait_for_irq_instruction = 1'b0;
        deep_sleep = 1'b0;
        irq_pending = 1'b0;
        async_wake = 1'b0;
    end
    // the only way to ask for sleep: a one-cycle strobe, depth given beside it
    task sleep(input logic deep);
        @(posedge clk);
        wait_for_irq_instruction <= 1'b1;
        deep_sleep <= deep;
        @(posedge clk);
        wait_for_irq_instruction <= 1'b0;
    endtask
    // interrupt level held n cycles, as a controller would until serviced
    task irq(input int n);
        @(posedge clk);
        irq_pending <= 1'b1;
        repeat (n) @(posedge clk);
        irq_pending <= 1'b0;
    endtask
    // wake line has no clock relation inside the chip; the two-flop stage absorbs any edge
    task wake(input int n);
        @(posedge clk);
        async_wake <= 1'b1;
        repeat (n) @(posedge clk);
        async_wake <= 1'b0;
    endtask
endmodule

// ===== tb/cpms_top_bench.sv
// bench: mode walks and register access of the power mode sequencer
`timescale 1ns/1ps
module cpms_top_bench
    import cpms_pkg::*;
;
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic [CPMS_ADDR_W-1:0] addr = '0;
    logic [CPMS_DATA_W-1:0] wdata = '0;
    logic                   wr = 1'b0;
    logic                   rd = 1'b0;
    logic [CPMS_DATA_W-1:0] rdata;
    logic [2:0]             mode;
    logic                   wait_for_irq_instruction, deep_sleep, irq_pending, async_wake;
    logic                   core_clk_en, periph_clk_en, regulator_lp, flash_slow;
    logic                   low_voltage_detect_en, nested_irq_controller_en;
    logic                   async_wakeup_controller_en, io_hold;
    int                     n_errors = 0;
    int                     comparisons = 0;
    // all enables in one byte so one compare covers a mode
    wire logic [7:0] outs_w = {core_clk_en, periph_clk_en, regulator_lp, flash_slow,
        low_voltage_detect_en, nested_irq_controller_en, async_wakeup_controller_en, io_hold};
    always #2.5 clk = ~clk;
    cpms_top i_cpms_top (.clk, .rst_b, .wait_for_irq_instruction, .deep_sleep, .irq_pending,
        .async_wake, .addr, .wdata, .wr, .rd, .rdata, .mode, .core_clk_en, .periph_clk_en,
        .regulator_lp, .flash_slow, .low_voltage_detect_en, .nested_irq_controller_en,
        .async_wakeup_controller_en, .io_hold);
    cpms_core_model i_cpms_core_model (.clk, .wait_for_irq_instruction, .deep_sleep,
        .irq_pending, .async_wake);
    // -------------------------
    // shared helpers
    // -------------------------
    // expected enables by mode, same bit order as outs_w
    function automatic logic [7:0] exp_outs(input logic [2:0] m);
        case (m)
            CPMS_MODE_RUN:   exp_outs = 8'hcc;
            CPMS_MODE_WAIT:  exp_outs = 8'h4d;
            CPMS_MODE_STOP:  exp_outs = 8'h0b;
            CPMS_MODE_VRUN:  exp_outs = 8'hf4;
            CPMS_MODE_VWAIT: exp_outs = 8'h75;
            default:         exp_outs = 8'h33;
        endcase
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // bounded wait for a mode, then its code and enables are judged off the edge
    // the leading step keeps the first look clear of the launching edge
    task wait_mode(input logic [2:0] m);
        #1;
        for (int i = 0; i < 20 && mode !== m; i++) begin
            @(posedge clk);
            #1;
        end
        if (mode !== m) begin
            chk({5'h0, mode}, {5'h0, m});  // timeout counts and reports as a mismatch
            tally_and_finish;
        end else begin
            chk({5'h0, mode}, {5'h0, m});
            chk(outs_w, exp_outs(m));
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read answer stands only in the cycle after the strobe
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // -------------------------
    // scenarios
    // -------------------------
    task t_regs;
        wr_reg(4'h0, 8'ha4);
        rd_chk(4'h0, 8'ha4);
        wr_reg(4'h4, 8'hff);  // read-only status must not take it
        rd_chk(4'h4, 8'h00);
        rd_chk(4'h0, 8'ha4);
        rd_chk(4'h8, 8'h00);  // unmapped reads as zero
        wr_reg(4'h0, 8'h00);
        $display("test registers done");
    endtask
    // sleep from a run mode, refuse a second strobe, then leave the proper way
    task t_sleep(input logic [2:0] run_m, input logic deep);
        logic [2:0] sm;
        sm = deep ? run_m + 3'h2 : run_m + 3'h1;
        i_cpms_core_model.sleep(deep);
        wait_mode(sm);
        i_cpms_core_model.sleep(1'b0);
        repeat (3) @(posedge clk);
        #1 chk({5'h0, mode}, {5'h0, sm});
        if (deep) begin
            i_cpms_core_model.irq(4);
            #1 chk({5'h0, mode}, {5'h0, sm});
            i_cpms_core_model.wake(8);
        end else begin
            i_cpms_core_model.irq(3);
        end
        wait_mode(run_m);
        $display("test sleep %0d deep %0d done", run_m, deep);
    endtask
    task t_vlp;
        wr_reg(4'h0, 8'h01);
        wait_mode(CPMS_MODE_VRUN);
        rd_chk(4'h4, 8'h03);
        t_sleep(CPMS_MODE_VRUN, 1'b0);
        t_sleep(CPMS_MODE_VRUN, 1'b1);
        wr_reg(4'h0, 8'h00);
        wait_mode(CPMS_MODE_RUN);
        $display("test vlp done");
    endtask
    // reset in mid-run from vlp run: back to full-power run, control cleared
    task t_reset;
        wr_reg(4'h0, 8'h81);
        wait_mode(CPMS_MODE_VRUN);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({5'h0, mode}, {5'h0, CPMS_MODE_RUN});
        chk(outs_w, exp_outs(CPMS_MODE_RUN));
        @(posedge clk);
        rst_b <= 1'b1;
        wait_mode(CPMS_MODE_RUN);
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h4, 8'h00);
        $display("test reset done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        wait_mode(CPMS_MODE_RUN);
        t_regs;
        t_sleep(CPMS_MODE_RUN, 1'b0);
        t_sleep(CPMS_MODE_RUN, 1'b1);
        t_vlp;
        t_reset;
        tally_and_finish;
    end
endmodule
